// file: hdl/usam_regs.vh
// register offsets, field positions and reset values for the status block
`ifndef USAM_REGS_VH
`define USAM_REGS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define USAM_ADDR_W 8
`define USAM_OFF_STATUS 8'h00
`define USAM_OFF_IRQ_STATUS 8'h04
`define USAM_OFF_IRQ_MASK 8'h08
`define USAM_OFF_MODE 8'h0C

// ****************************************
// status register fields
// ****************************************
`define USAM_MASK_HI 31
`define USAM_MASK_LO 24
`define USAM_ADDR_HI 23
`define USAM_ADDR_LO 16
`define USAM_TXISEL_HI 15
`define USAM_TXISEL_LO 14
`define USAM_TXINV 13
`define USAM_RXEN 12
`define USAM_TXBRK 11
`define USAM_TXEN 10
`define USAM_TXBF 9
`define USAM_TX_SHIFT_EMPTY 8
`define USAM_RXISEL_HI 7
`define USAM_RXISEL_LO 6
`define USAM_STATION_DETECT_ENABLE 5
`define USAM_RECEIVER_IDLE 4
`define USAM_PARITY_ERROR_FLAG 3
`define USAM_FRAMING_ERROR_FLAG 2
`define USAM_OVERRUN_ERROR_FLAG 1
`define USAM_RX_DATA_AVAILABLE 0

// ****************************************
// mode register fields (module on, infrared)
// ****************************************
`define USAM_MODE_ON 15
`define USAM_MODE_INFRARED_ENCODING_ENABLE 12

// ****************************************
// interrupt status / mask bits
// ****************************************
`define USAM_IRQ_W 4
`define USAM_IRQ_TX 0
`define USAM_IRQ_MATCH 1
`define USAM_IRQ_OVERRUN_ERROR_FLAG 2
`define USAM_IRQ_BRK 3

// ****************************************
// encodings and reset values
// ****************************************
`define USAM_TXSEL_SLOT 2'h0
`define USAM_TXSEL_DONE 2'h1
`define USAM_TXSEL_EMPTY 2'h2
`define USAM_ZERO32 32'h00000000
`define USAM_ZERO8 8'h00
`define USAM_ZERO4 4'h0
`define USAM_ZERO2 2'h0

`endif

// file: hdl/usam_match.v
// address comparator with a per-bit mask
`timescale 1ns/1ns
`default_nettype none
`include "usam_regs.vh"

// ****************************************
// registered address match
// ****************************************
module usam_match (
	input wire i_ref_clk,
	input wire i_reset,
	input wire [7:0] i_mask,
	input wire [7:0] i_station,
	input wire [7:0] i_addr_char,
	input wire i_addr_valid,
	output reg o_match
);
	// a zero mask bit drops that position, so all zeros matches anything
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_match <= 1'b0;
		end else begin
			o_match <= i_addr_valid &
				(((i_addr_char ^ i_station) & i_mask) == `USAM_ZERO8);
		end
	end
endmodule // usam_match

`default_nettype wire

// file: hdl/usam_top.v
// status and control register block of an asynchronous serial port
// What this block does
// - mask bits choose which address bits compare
// - station value compared at enabled mask positions
// - transmit interrupt: empty, all sent, slot free
// - infrared off: polarity set means idle low
// - infrared on: polarity set means idle high
// - receiver enable plus module on owns pin
// - receiver off keeps buffer and flags
// - transmitter enable plus module on raises interrupt if condition holds
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "usam_regs.vh"

// ****************************************
// register map
// ****************************************
// 0x00 status and control, field layout below
// 0x04 interrupt status, write one to clear
// 0x08 interrupt mask, same layout as interrupt status
// 0x0C mode: module on and infrared enable
// unmapped offsets read zero, writes dropped
// interrupt bits: 0 transmit, 1 station match,
// 2 overrun, 3 break sent
// status 31:24 match mask, 23:16 station value,
// 15:14 tx select, 13 polarity, 12 receiver on,
// 11 break, 10 transmitter on, 9 buffer full,
// 8 shift empty, 7:6 rx select, 5 station detect,
// 4 receiver idle, 3 parity, 2 framing,
// 1 overrun, 0 receive data ready

module usam_top (
	input wire i_ref_clk,
	input wire i_reset,
	// register bus, read data one cycle after the strobe
	input wire [7:0] i_bus_addr,
	input wire [31:0] i_bus_wdata,
	input wire i_bus_write,
	input wire i_bus_read,
	output reg [31:0] o_bus_rdata,
	// levels and pulses from the transmit and receive paths
	input wire i_tx_buffer_full,
	input wire i_tx_buffer_empty,
	input wire i_tx_shift_empty,
	input wire i_receiver_idle,
	input wire i_parity_error,
	input wire i_framing_error,
	input wire i_overrun_event,
	input wire i_rx_data_available,
	input wire i_break_sent,
	// received address character and raw line levels
	input wire [7:0] i_addr_char,
	input wire i_addr_valid,
	input wire i_tx_line_raw,
	input wire i_tx_ir_raw,
	// pin and level outputs, all registered
	output reg o_serial_out_pin,
	output reg o_rx_pin_owned,
	output reg o_tx_irq_level,
	output reg o_station_match,
	output reg o_transmitter_enable,
	output reg o_tx_break_request,
	output reg o_irq
);

	// ****************************************
	// control and status state
	// ****************************************
	reg [7:0] match_mask;
	reg [7:0] station_value;
	reg [1:0] tx_irq_condition_select;
	reg tx_polarity_invert;
	reg receiver_enable;
	reg tx_break_request;
	reg transmitter_enable;
	reg [1:0] rx_irq_condition_select;
	reg station_detect_enable;
	reg overrun_error_flag;
	reg module_on;
	reg infrared_encoding_enable;
	reg [3:0] irq_status;
	reg [3:0] irq_mask;
	// live values mirrored from the transmit and receive paths
	reg tx_shift_empty;
	reg receiver_idle;
	reg tx_buffer_full;
	reg parity_error_flag;
	reg framing_error_flag;
	reg rx_data_available;
	wire match_hit;
	// combinational next values
	reg tx_cond;
	reg [3:0] next_irq_status;
	reg [31:0] next_rdata;
	wire wr_status;
	wire wr_irq_status;
	wire wr_irq_mask;
	wire wr_mode;

	// ****************************************
	// helpers
	// ****************************************
	// address compare shared by all write decodes
	// one compare for read and write keeps the two decodes in step
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	assign wr_status = i_bus_write & hit(i_bus_addr, `USAM_OFF_STATUS);
	assign wr_irq_status = i_bus_write & hit(i_bus_addr, `USAM_OFF_IRQ_STATUS);
	assign wr_irq_mask = i_bus_write & hit(i_bus_addr, `USAM_OFF_IRQ_MASK);
	assign wr_mode = i_bus_write & hit(i_bus_addr, `USAM_OFF_MODE);

	// ****************************************
	// address match
	// ****************************************
	// a char seen while station detect or module on is off is dropped,
	// not held for later
	usam_match u_match (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_mask(match_mask),
		.i_station(station_value),
		.i_addr_char(i_addr_char),
		.i_addr_valid(i_addr_valid & station_detect_enable & module_on),
		.o_match(match_hit)
	);

	// ****************************************
	// transmit interrupt condition
	// ****************************************
	// 11 is reserved; it never asserts, so a bad setting stays quiet
	// all sent means buffer empty and shift register drained
	always @* begin
		case (tx_irq_condition_select)
		`USAM_TXSEL_EMPTY: tx_cond = i_tx_buffer_empty;
		`USAM_TXSEL_DONE: tx_cond = i_tx_buffer_empty & i_tx_shift_empty;
		`USAM_TXSEL_SLOT: tx_cond = ~i_tx_buffer_full;
		default: tx_cond = 1'b0;
		endcase
	end

	// ****************************************
	// control register writes
	// ****************************************
	// break request self-clears; a write of one in the same cycle wins
	// rx select is only stored and read back; the receive interrupt
	// itself lives in the receive path, outside this block
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			match_mask <= `USAM_ZERO8;
			station_value <= `USAM_ZERO8;
			tx_irq_condition_select <= `USAM_ZERO2;
			tx_polarity_invert <= 1'b0;
			receiver_enable <= 1'b0;
			tx_break_request <= 1'b0;
			transmitter_enable <= 1'b0;
			rx_irq_condition_select <= `USAM_ZERO2;
			station_detect_enable <= 1'b0;
			module_on <= 1'b0;
			infrared_encoding_enable <= 1'b0;
			irq_mask <= `USAM_ZERO4;
		end else begin
			if (wr_status) begin
				match_mask <= i_bus_wdata[`USAM_MASK_HI:`USAM_MASK_LO];
				station_value <= i_bus_wdata[`USAM_ADDR_HI:`USAM_ADDR_LO];
				tx_irq_condition_select <=
					i_bus_wdata[`USAM_TXISEL_HI:`USAM_TXISEL_LO];
				tx_polarity_invert <= i_bus_wdata[`USAM_TXINV];
				receiver_enable <= i_bus_wdata[`USAM_RXEN];
				transmitter_enable <= i_bus_wdata[`USAM_TXEN];
				rx_irq_condition_select <=
					i_bus_wdata[`USAM_RXISEL_HI:`USAM_RXISEL_LO];
				station_detect_enable <= i_bus_wdata[`USAM_STATION_DETECT_ENABLE];
			end
			if (wr_status & i_bus_wdata[`USAM_TXBRK]) begin
				tx_break_request <= 1'b1;
			end else if (i_break_sent) begin
				tx_break_request <= 1'b0;
			end
			if (wr_mode) begin
				module_on <= i_bus_wdata[`USAM_MODE_ON];
				infrared_encoding_enable <= i_bus_wdata[`USAM_MODE_INFRARED_ENCODING_ENABLE];
			end
			if (wr_irq_mask) begin
				irq_mask <= i_bus_wdata[`USAM_IRQ_W-1:0];
			end
		end
	end

	// ****************************************
	// receive status flags
	// ****************************************
	// sampled every cycle regardless of the receiver enable, so turning
	// the receiver off leaves what the receive path reports untouched
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			tx_shift_empty <= 1'b1;
			receiver_idle <= 1'b1;
			tx_buffer_full <= 1'b0;
			parity_error_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			rx_data_available <= 1'b0;
			overrun_error_flag <= 1'b0;
		end else begin
			tx_shift_empty <= i_tx_shift_empty;
			receiver_idle <= i_receiver_idle;
			tx_buffer_full <= i_tx_buffer_full;
			parity_error_flag <= i_parity_error;
			framing_error_flag <= i_framing_error;
			rx_data_available <= i_rx_data_available;
			// hardware set beats a software clear in the same cycle
			// any status write with this bit at zero clears it, so software
			// must read-modify-write to keep a pending overrun
			if (i_overrun_event) begin
				overrun_error_flag <= 1'b1;
			end else if (wr_status & ~i_bus_wdata[`USAM_OVERRUN_ERROR_FLAG]) begin
				overrun_error_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// sticky interrupt status
	// ****************************************
	// the transmit event is the condition while the transmitter is on,
	// so enabling it with the condition true fires at once
	// a write-one clear loses to a set in the same cycle, so no event
	// slips through a clear
	always @* begin
		next_irq_status = irq_status;
		if (wr_irq_status) begin
			next_irq_status = irq_status & ~i_bus_wdata[`USAM_IRQ_W-1:0];
		end
		if (transmitter_enable & module_on & tx_cond) begin
			next_irq_status[`USAM_IRQ_TX] = 1'b1;
		end
		if (match_hit) begin
			next_irq_status[`USAM_IRQ_MATCH] = 1'b1;
		end
		if (i_overrun_event) begin
			next_irq_status[`USAM_IRQ_OVERRUN_ERROR_FLAG] = 1'b1;
		end
		if (i_break_sent & tx_break_request) begin
			next_irq_status[`USAM_IRQ_BRK] = 1'b1;
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			irq_status <= `USAM_ZERO4;
			o_irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			o_irq <= |(next_irq_status & irq_mask);
		end
	end

	// ****************************************
	// pins and level outputs
	// ****************************************
	// idle of the raw encoder is high on the plain line and low on the
	// infrared path; the polarity bit flips each one
	// levels lag the raw inputs by one cycle, so the pin never glitches
	// while a setting changes
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_serial_out_pin <= 1'b1;
			o_rx_pin_owned <= 1'b0;
			o_tx_irq_level <= 1'b0;
			o_station_match <= 1'b0;
			o_transmitter_enable <= 1'b0;
			o_tx_break_request <= 1'b0;
		end else begin
			if (infrared_encoding_enable) begin
				o_serial_out_pin <= i_tx_ir_raw ^ tx_polarity_invert;
			end else begin
				o_serial_out_pin <= i_tx_line_raw ^ tx_polarity_invert;
			end
			o_rx_pin_owned <= receiver_enable & module_on;
			o_tx_irq_level <= transmitter_enable & module_on & tx_cond;
			o_station_match <= match_hit;
			// transmitter is gated by module on, in case software skips order
			o_transmitter_enable <= transmitter_enable & module_on;
			o_tx_break_request <= tx_break_request;
		end
	end

	// ****************************************
	// register read
	// ****************************************
	// unmapped offsets fall through to zero
	always @* begin
		next_rdata = `USAM_ZERO32;
		if (hit(i_bus_addr, `USAM_OFF_STATUS)) begin
			next_rdata[`USAM_MASK_HI:`USAM_MASK_LO] = match_mask;
			next_rdata[`USAM_ADDR_HI:`USAM_ADDR_LO] = station_value;
			next_rdata[`USAM_TXISEL_HI:`USAM_TXISEL_LO] =
				tx_irq_condition_select;
			next_rdata[`USAM_TXINV] = tx_polarity_invert;
			next_rdata[`USAM_RXEN] = receiver_enable;
			next_rdata[`USAM_TXBRK] = tx_break_request;
			next_rdata[`USAM_TXEN] = transmitter_enable;
			next_rdata[`USAM_TXBF] = tx_buffer_full;
			next_rdata[`USAM_TX_SHIFT_EMPTY] = tx_shift_empty;
			next_rdata[`USAM_RXISEL_HI:`USAM_RXISEL_LO] =
				rx_irq_condition_select;
			next_rdata[`USAM_STATION_DETECT_ENABLE] = station_detect_enable;
			next_rdata[`USAM_RECEIVER_IDLE] = receiver_idle;
			next_rdata[`USAM_PARITY_ERROR_FLAG] = parity_error_flag;
			next_rdata[`USAM_FRAMING_ERROR_FLAG] = framing_error_flag;
			next_rdata[`USAM_OVERRUN_ERROR_FLAG] = overrun_error_flag;
			next_rdata[`USAM_RX_DATA_AVAILABLE] = rx_data_available;
		end else if (hit(i_bus_addr, `USAM_OFF_IRQ_STATUS)) begin
			next_rdata[`USAM_IRQ_W-1:0] = irq_status;
		end else if (hit(i_bus_addr, `USAM_OFF_IRQ_MASK)) begin
			next_rdata[`USAM_IRQ_W-1:0] = irq_mask;
		end else if (hit(i_bus_addr, `USAM_OFF_MODE)) begin
			next_rdata[`USAM_MODE_ON] = module_on;
			next_rdata[`USAM_MODE_INFRARED_ENCODING_ENABLE] = infrared_encoding_enable;
		end
	end

	// read data stand only in the cycle after the strobe
	// reads have no side effects; overrun and interrupt status flags clear only by writes
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_bus_rdata <= `USAM_ZERO32;
		end else if (i_bus_read) begin
			o_bus_rdata <= next_rdata;
		end else begin
			o_bus_rdata <= `USAM_ZERO32;
		end
	end

endmodule // usam_top

`default_nettype wire

// file: tb/usam_station_model.sv
// line-side station model: address characters and raw line levels
`timescale 1ns/1ns
`default_nettype none
module usam_station_model (
	input wire logic i_ref_clk,
	input wire logic i_send,
	input wire logic i_mark,
	input wire logic [7:0] i_char,
	output logic [7:0] o_addr_char,
	output logic o_addr_valid,
	output logic o_tx_line_raw,
	output logic o_tx_ir_raw
);
	// off-strobe the char flips so stale data can never pass for a match
	always @(posedge i_ref_clk) begin
		o_addr_valid <= i_send;
		o_addr_char <= i_send ? i_char : ~o_addr_char;
		o_tx_line_raw <= !i_mark; // line idles high, mark drives low
		o_tx_ir_raw <= i_mark; // encoded line idles low
	end
	initial begin
		o_addr_char = 8'h00;
		o_addr_valid = 1'b0;
		o_tx_line_raw = 1'b1;
		o_tx_ir_raw = 1'b0;
	end
endmodule // usam_station_model
`default_nettype wire

// file: tb/usam_checker_assertions.sv
// port-level concurrent checks for the status block
`timescale 1ns/1ns
`default_nettype none
module usam_checker (
	input wire i_ref_clk,
	input wire i_reset,
	input wire [7:0] i_bus_addr,
	input wire i_bus_write,
	input wire i_bus_read,
	input wire [31:0] o_bus_rdata,
	input wire i_overrun_event,
	input wire i_break_sent,
	input wire i_tx_buffer_full,
	input wire i_tx_buffer_empty,
	input wire i_addr_valid,
	input wire i_tx_line_raw,
	input wire i_tx_ir_raw,
	input wire o_serial_out_pin,
	input wire o_tx_irq_level,
	input wire o_station_match,
	input wire o_transmitter_enable,
	input wire o_tx_break_request,
	input wire o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	property p_rd_idle;
		!$past(i_bus_read) |-> o_bus_rdata == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_rd_unmapped;
		$past(i_bus_read) && $past(i_bus_addr) == 8'h10 |-> o_bus_rdata == 0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");
	property p_match_lat;
		o_station_match |-> $past(i_addr_valid, 2);
	endproperty
	a_match_lat: assert property (p_match_lat) else $error("match lat");
	// the pin may only move when a raw level or a setting moved
	property p_pol_stable;
		$stable(i_tx_line_raw) && $stable(i_tx_ir_raw) && !$past(i_bus_write)
		|=> $stable(o_serial_out_pin);
	endproperty
	a_pol_stable: assert property (p_pol_stable) else $error("pin moved");
	property p_txirq_en;
		o_tx_irq_level |-> o_transmitter_enable &&
			($past(i_tx_buffer_empty) || !$past(i_tx_buffer_full));
	endproperty
	a_txirq_en: assert property (p_txirq_en) else $error("tx irq off");
	property p_brk_hold;
		o_tx_break_request && !i_break_sent && !$past(i_break_sent)
		|=> o_tx_break_request;
	endproperty
	a_brk_hold: assert property (p_brk_hold) else $error("break lost");
	property p_brk_clr;
		i_break_sent && !i_bus_write |-> ##2 !o_tx_break_request;
	endproperty
	a_brk_clr: assert property (p_brk_clr) else $error("break kept");
	property p_irq_cause;
		$rose(o_irq) |-> $past(i_overrun_event) || $past(i_break_sent)
		|| o_station_match || $past(o_station_match) || o_tx_irq_level
		|| $past(o_tx_irq_level) || $past(i_bus_write) || $past(i_bus_write, 2);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
endmodule // usam_checker
bind usam_top usam_checker usam_checker_inst (.i_ref_clk(i_ref_clk),
	.i_reset(i_reset), .i_bus_addr(i_bus_addr), .i_bus_write(i_bus_write),
	.i_bus_read(i_bus_read), .o_bus_rdata(o_bus_rdata),
	.i_overrun_event(i_overrun_event), .i_break_sent(i_break_sent),
	.i_tx_buffer_full(i_tx_buffer_full),
	.i_tx_buffer_empty(i_tx_buffer_empty),
	.i_addr_valid(i_addr_valid), .i_tx_line_raw(i_tx_line_raw),
	.i_tx_ir_raw(i_tx_ir_raw), .o_serial_out_pin(o_serial_out_pin),
	.o_tx_irq_level(o_tx_irq_level), .o_station_match(o_station_match),
	.o_transmitter_enable(o_transmitter_enable),
	.o_tx_break_request(o_tx_break_request), .o_irq(o_irq));
`default_nettype wire

// file: tb/tb_usam_top.sv
// self-checking bench for the status block
`timescale 1ns/1ns
`default_nettype none
`include "usam_regs.vh"
`define TB_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_usam_top;
	logic i_ref_clk = 1'b0, i_reset = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic [7:0] adr = 8'h00, ch = 8'h00, a_ch;
	logic [31:0] wd = 32'h00000000, rdata, d;
	logic full = 1'b0, emp = 1'b1, sh = 1'b1, idl = 1'b1, pe = 1'b0;
	logic fe = 1'b0, ovr = 1'b0, rda = 1'b0, bs = 1'b0, snd = 1'b0, mk = 1'b0;
	logic a_v, raw, irr, so, own, txl, sm, te, br, irq;
	int n_fail = 0, samples_checked = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	usam_top usam_top_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.i_bus_addr(adr), .i_bus_wdata(wd), .i_bus_write(wr_s),
		.i_bus_read(rd_s), .o_bus_rdata(rdata), .i_tx_buffer_full(full),
		.i_tx_buffer_empty(emp), .i_tx_shift_empty(sh), .i_receiver_idle(idl),
		.i_parity_error(pe), .i_framing_error(fe), .i_overrun_event(ovr),
		.i_rx_data_available(rda), .i_break_sent(bs), .i_addr_char(a_ch),
		.i_addr_valid(a_v), .i_tx_line_raw(raw), .i_tx_ir_raw(irr),
		.o_serial_out_pin(so), .o_rx_pin_owned(own), .o_tx_irq_level(txl),
		.o_station_match(sm), .o_transmitter_enable(te),
		.o_tx_break_request(br), .o_irq(irq));
	usam_station_model usam_station_model_inst (.i_ref_clk(i_ref_clk),
		.i_send(snd), .i_mark(mk), .i_char(ch), .o_addr_char(a_ch),
		.o_addr_valid(a_v), .o_tx_line_raw(raw), .o_tx_ir_raw(irr));
	// ****************************************
	// bus cycles
	// ****************************************
	task wr(input [7:0] a, input [31:0] v);
		@(posedge i_ref_clk);
		wr_s <= 1'b1;
		adr <= a;
		wd <= v;
		@(posedge i_ref_clk);
		wr_s <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task rd(input [7:0] a);
		@(posedge i_ref_clk);
		rd_s <= 1'b1;
		adr <= a;
		@(posedge i_ref_clk);
		rd_s <= 1'b0;
		@(negedge i_ref_clk);
		d = rdata;
	endtask
	task settle;
		repeat (3) @(posedge i_ref_clk);
		#1;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		rd(`USAM_OFF_STATUS);
		`TB_CHK(d, 32'h00000110)
		rd(8'h10);
		`TB_CHK(d, 32'h00000000)
		$display("reset test done");
	endtask
	task t_match;
		logic [24:0] tab [0:3];
		logic hit;
		tab[0] = {8'hFF, 8'hA5, 8'hA5, 1'b1};
		tab[1] = {8'hFF, 8'hA5, 8'hA4, 1'b0};
		tab[2] = {8'h0F, 8'hA5, 8'hA3, 1'b0};
		tab[3] = {8'h00, 8'hA5, 8'h3C, 1'b1};
		wr(`USAM_OFF_MODE, 32'h00008000);
		for (int i = 0; i < 4; i++) begin
			wr(`USAM_OFF_STATUS, {tab[i][24:9], 16'h0020});
			snd <= 1'b1;
			ch <= tab[i][8:1];
			@(posedge i_ref_clk);
			snd <= 1'b0;
			hit = 1'b0;
			repeat (5) begin
				@(posedge i_ref_clk);
				#1 hit = hit | sm;
			end
			`TB_CHK(hit, tab[i][0])
		end
		rd(`USAM_OFF_IRQ_STATUS);
		`TB_CHK(d[1], 1'b1)
		$display("match test done");
	endtask
	task t_txirq;
		logic ex;
		// k: all sent, empty but shifting, full, part filled
		for (int k = 0; k < 4; k++) begin
			@(posedge i_ref_clk);
			full <= (k == 2);
			emp <= (k < 2);
			sh <= (k == 0 || k == 3);
			for (int s = 0; s < 4; s++) begin
				wr(`USAM_OFF_STATUS, {16'h0000, s[1:0], 14'h0400});
				settle();
				ex = (s == 0 && k != 2) || (s == 1 && k == 0);
				ex = ex || (s == 2 && k < 2);
				`TB_CHK(txl, ex)
			end
		end
		// buffer empty again, so the empty condition holds before enabling
		@(posedge i_ref_clk);
		full <= 1'b0;
		emp <= 1'b1;
		wr(`USAM_OFF_STATUS, 32'h00000000);
		wr(`USAM_OFF_IRQ_STATUS, 32'h0000000F);
		wr(`USAM_OFF_IRQ_MASK, 32'h00000001);
		settle();
		`TB_CHK(irq, 1'b0)
		wr(`USAM_OFF_STATUS, 32'h00008400);
		settle();
		`TB_CHK(irq, 1'b1)
		wr(`USAM_OFF_STATUS, 32'h00000000);
		wr(`USAM_OFF_IRQ_STATUS, 32'h0000000F);
		wr(`USAM_OFF_IRQ_MASK, 32'h00000000);
		settle();
		`TB_CHK(irq, 1'b0)
		$display("tx irq test done");
	endtask
	// idle level first, then one marked bit through the pin
	task t_pol;
		logic ir, inv;
		for (int m = 0; m < 4; m++) begin
			ir = m[1];
			inv = m[0];
			wr(`USAM_OFF_MODE, {16'h0000, 1'b1, 2'b00, ir, 12'h000});
			wr(`USAM_OFF_STATUS, {18'h00000, inv, 13'h0000});
			settle();
			`TB_CHK(so, ~ir ^ inv)
			@(posedge i_ref_clk);
			mk <= 1'b1;
			repeat (2) @(posedge i_ref_clk);
			#1 `TB_CHK(so, ir ^ inv)
			@(posedge i_ref_clk);
			mk <= 1'b0;
		end
		$display("polarity test done");
	endtask
	task t_rx;
		wr(`USAM_OFF_MODE, 32'h00008000);
		pe <= 1'b1;
		rda <= 1'b1;
		wr(`USAM_OFF_STATUS, 32'h00001000);
		settle();
		`TB_CHK(own, 1'b1)
		wr(`USAM_OFF_STATUS, 32'h00000000);
		settle();
		`TB_CHK(own, 1'b0)
		rd(`USAM_OFF_STATUS);
		`TB_CHK({d[3], d[0]}, 2'h3)
		wr(`USAM_OFF_STATUS, 32'h00001000);
		wr(`USAM_OFF_MODE, 32'h00000000);
		settle();
		`TB_CHK(own, 1'b0)
		$display("receiver test done");
	endtask
	task t_brk;
		wr(`USAM_OFF_STATUS, 32'h00000800);
		settle();
		`TB_CHK(br, 1'b1)
		wr(`USAM_OFF_STATUS, 32'h00000000);
		settle();
		`TB_CHK(br, 1'b1)
		@(posedge i_ref_clk);
		bs <= 1'b1;
		ovr <= 1'b1;
		@(posedge i_ref_clk);
		bs <= 1'b0;
		ovr <= 1'b0;
		settle();
		`TB_CHK({br, irq}, 2'h0)
		rd(`USAM_OFF_STATUS);
		`TB_CHK(d[1], 1'b1)
		wr(`USAM_OFF_IRQ_MASK, 32'h00000004);
		settle();
		`TB_CHK(irq, 1'b1)
		rd(`USAM_OFF_IRQ_STATUS);
		`TB_CHK(d[3:2], 2'h3)
		wr(`USAM_OFF_STATUS, 32'h00000000);
		wr(`USAM_OFF_IRQ_STATUS, 32'h0000000F);
		rd(`USAM_OFF_STATUS);
		`TB_CHK({d[1], irq}, 2'h0)
		// overrun event and a clearing write in one cycle: the set wins
		@(posedge i_ref_clk);
		ovr <= 1'b1;
		wr_s <= 1'b1;
		adr <= `USAM_OFF_STATUS;
		wd <= 32'h00000000;
		@(posedge i_ref_clk);
		ovr <= 1'b0;
		wr_s <= 1'b0;
		rd(`USAM_OFF_STATUS);
		`TB_CHK(d[1], 1'b1)
		$display("break and overrun test done");
	endtask
	task stop_test;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// reset held four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		t_reset();
		t_match();
		t_txirq();
		t_pol();
		t_rx();
		t_brk();
		stop_test();
	end
endmodule // tb_usam_top
`default_nettype wire
